// file: rtl/svs_pkg.sv
// Sequencer constants: register map, fields, limits.
// Assumes a 32-bit AXI4-Lite register bus with one aligned word per register.
package svs_pkg;
    localparam int          VEC_W         = 48;
    localparam int          MEM_AW        = 24;
    localparam int          NUM_COND      = 4;
    localparam int          PAT_W         = 3;

    localparam logic [7:0]  OFF_CTRL      = 8'h00;
    localparam logic [7:0]  OFF_STATUS    = 8'h04;
    localparam logic [7:0]  OFF_CLK_MHZ   = 8'h08;
    localparam logic [7:0]  OFF_STROBE    = 8'h0c;
    localparam logic [7:0]  OFF_INIT_LEN  = 8'h10;
    localparam logic [7:0]  OFF_MAIN_LEN  = 8'h14;
    localparam logic [7:0]  OFF_COND      = 8'h18;
    localparam logic [7:0]  OFF_VEC_ADDR  = 8'h1c;
    localparam logic [7:0]  OFF_VEC_LO    = 8'h20;
    localparam logic [7:0]  OFF_VEC_HI    = 8'h24;

    localparam int          CTRL_RUN      = 0;
    localparam int          CTRL_REPEAT   = 1;
    localparam int          CTRL_EXT_CLK  = 2;
    localparam int          ST_RUNNING    = 0;
    localparam int          ST_WAITING    = 1;
    localparam int          ST_DONE       = 2;

    localparam int          HI_OP_LSB     = 16;
    localparam int          HI_SEL_LSB    = 18;
    localparam logic [1:0]  OP_VECTOR     = 2'h0;
    localparam logic [1:0]  OP_ARM        = 2'h1;
    localparam logic [1:0]  OP_WAIT       = 2'h2;
    localparam logic [2:0]  SEL_ARM_IN    = 3'h4;

    localparam logic [8:0]  CLK_MHZ_MIN   = 9'h001;
    localparam logic [8:0]  CLK_MHZ_MAX   = 9'h12c;
    localparam logic [8:0]  CLK_MHZ_RST   = 9'h064;
    localparam int          STROBE_MAX_PS = 8000;
    localparam int          STROBE_STEP_PS = 250;
    localparam logic [5:0]  STROBE_MAX    = 6'(STROBE_MAX_PS / STROBE_STEP_PS);
    localparam int          EXT_HIGH_MIN_PS = 2000;

    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;
endpackage

// file: rtl/svs_sync.sv
// Three-stage synchroniser with settle filter.
// Assumes a level held for several destination clocks.
`timescale 1ns/1ps
module svs_sync #(
    parameter int W = 1
) (
    input  wire logic         i_clock,   // Destination clock
    input  wire logic         i_reset_n, // Async reset, active low
    input  wire logic [W-1:0] i_async,   // Level from another domain
    output logic      [W-1:0] o_sync     // Settled level
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;

    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
        end else begin
            s1_r <= i_async;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // A new value counts only once stages two and three agree
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_sync <= '0;
        end else if (s2_r == s3_r) begin
            o_sync <= s3_r;
        end
    end
endmodule // svs_sync

// file: rtl/svs_sequencer.sv
// Stimulus vector sequencer: vector store, AXI4-Lite registers, link-side player.
// Assumes i_vec_clock is the selected output clock (internal synth or pod input).
// Operation
// - Each stored vector of up to 48 bits is driven out at a rising edge of the output clock.
// - The vector store holds and replays a program of up to sixteen mega-vectors per run.
// - Output is timed by an internal or external clock; an external high phase is at least 2 ns.
// - The internal clock is programmable from 1 MHz to 300 MHz in 1 MHz steps.
// - A strobe output follows the vector clock with a delay adjustable up to 8 ns.
// - In repeat mode the start-up sequence plays once, then the main sequence loops.
// - The arm-output instruction issues an arming event for an attached instrument.
// - The 3-bit external input is sampled by level and held steady by the outside party.
// - Up to four wait conditions each OR any subset of the eight 3-bit input values.
// - A wait instruction may instead wait for the incoming arm signal.
// - While a wait is pending no following vector is output until its condition is true.
`timescale 1ns/1ps
module svs_sequencer #(
    parameter int VEC_W  = svs_pkg::VEC_W,
    parameter int MEM_AW = svs_pkg::MEM_AW
) (
    input  wire logic             i_clock,          // System clock
    input  wire logic             i_reset_n,        // Reset, active low
    input  wire logic             i_vec_clock,      // Output clock
    input  wire logic [7:0]       i_awaddr,         // AW address
    input  wire logic             i_awvalid,        // AW valid
    output logic                  o_awready,        // AW ready
    input  wire logic [31:0]      i_wdata,          // W data
    input  wire logic [3:0]       i_wstrb,          // W strobes
    input  wire logic             i_wvalid,         // W valid
    output logic                  o_wready,         // W ready
    output logic [1:0]            o_bresp,          // B response
    output logic                  o_bvalid,         // B valid
    input  wire logic             i_bready,         // B ready
    input  wire logic [7:0]       i_araddr,         // AR address
    input  wire logic             i_arvalid,        // AR valid
    output logic                  o_arready,        // AR ready
    output logic [31:0]           o_rdata,          // R data
    output logic [1:0]            o_rresp,          // R response
    output logic                  o_rvalid,         // R valid
    input  wire logic             i_rready,         // R ready
    input  wire logic [2:0]       i_pattern,        // Wait pattern pins
    input  wire logic             i_arm_in,         // Arm in, level
    output logic [VEC_W-1:0]      o_vector,         // Stimulus vector
    output logic                  o_arm_out,        // Arm pulse
    output logic                  o_clk_ext_sel,    // Use pod clock
    output logic [8:0]            o_clk_mhz,        // Synth MHz
    output logic                  o_strobe,         // Gated output clock
    output logic [5:0]            o_strobe_delay    // Delay, 250 ps steps
);
    localparam int LW = MEM_AW + 1;
    localparam int IW = VEC_W + 5;

    typedef enum logic [2:0] {SVS_IDLE, SVS_PLAY, SVS_WAIT, SVS_DONE} svs_state_t;

    // ---------------- System domain registers ----------------
    logic             run_r;
    logic             repeat_r;
    logic [8:0]       clk_mhz_r;
    logic [5:0]       strobe_r;
    logic [LW-1:0]    init_len_r;
    logic [LW-1:0]    main_len_r;
    logic [31:0]      cond_r;
    logic [MEM_AW-1:0] vec_addr_r;
    logic [31:0]      vec_lo_r;
    logic [IW-1:0]    mem [0:(1<<MEM_AW)-1];
    logic             ext_clk_r;

    logic             aw_held_r;
    logic [7:0]       aw_addr_r;
    logic             w_held_r;
    logic [31:0]      w_data_r;
    logic [3:0]       w_strb_r;
    logic             wr_go;
    logic [31:0]      rd_word;
    logic             rd_hit;
    logic [2:0]       status_sys;

    function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic [8:0] clamp_mhz(input logic [8:0] v);
        if (v < svs_pkg::CLK_MHZ_MIN) begin
            return svs_pkg::CLK_MHZ_MIN;
        end else if (v > svs_pkg::CLK_MHZ_MAX) begin
            return svs_pkg::CLK_MHZ_MAX;
        end
        return v;
    endfunction

    // Address and data are latched independently, so either may come first
    assign o_awready = !aw_held_r;
    assign o_wready  = !w_held_r;
    assign wr_go     = aw_held_r && w_held_r && !o_bvalid;
    assign o_arready = !o_rvalid;

    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            aw_held_r <= 1'b0;
            aw_addr_r <= 8'h00;
            w_held_r  <= 1'b0;
            w_data_r  <= 32'h0000_0000;
            w_strb_r  <= 4'h0;
        end else begin
            if (i_awvalid && o_awready) begin
                aw_held_r <= 1'b1;
                aw_addr_r <= i_awaddr;
            end else if (wr_go) begin
                aw_held_r <= 1'b0;
            end
            if (i_wvalid && o_wready) begin
                w_held_r <= 1'b1;
                w_data_r <= i_wdata;
                w_strb_r <= i_wstrb;
            end else if (wr_go) begin
                w_held_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_bvalid <= 1'b0;
            o_bresp  <= svs_pkg::RESP_OKAY;
        end else if (wr_go) begin
            o_bvalid <= 1'b1;
            o_bresp  <= (aw_addr_r[1:0] == 2'h0 && aw_addr_r <= svs_pkg::OFF_VEC_HI &&
                         aw_addr_r != svs_pkg::OFF_STATUS) ? svs_pkg::RESP_OKAY
                                                           : svs_pkg::RESP_SLVERR;
        end else if (i_bready) begin
            o_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            run_r      <= 1'b0;
            repeat_r   <= 1'b0;
            ext_clk_r  <= 1'b0;
            clk_mhz_r  <= svs_pkg::CLK_MHZ_RST;
            strobe_r   <= 6'h00;
            init_len_r <= '0;
            main_len_r <= '0;
            cond_r     <= 32'h0000_0000;
            vec_addr_r <= '0;
            vec_lo_r   <= 32'h0000_0000;
        end else if (wr_go) begin
            case (aw_addr_r)
                svs_pkg::OFF_CTRL: begin
                    run_r     <= w_strb_r[0] ? w_data_r[svs_pkg::CTRL_RUN] : run_r;
                    repeat_r  <= w_strb_r[0] ? w_data_r[svs_pkg::CTRL_REPEAT] : repeat_r;
                    ext_clk_r <= w_strb_r[0] ? w_data_r[svs_pkg::CTRL_EXT_CLK] : ext_clk_r;
                end
                svs_pkg::OFF_CLK_MHZ: begin
                    clk_mhz_r <= clamp_mhz(9'(merge({23'h0, clk_mhz_r}, w_data_r, w_strb_r)));
                end
                svs_pkg::OFF_STROBE: begin
                    if (w_strb_r[0]) begin
                        strobe_r <= (w_data_r[5:0] > svs_pkg::STROBE_MAX) ? svs_pkg::STROBE_MAX
                                                                          : w_data_r[5:0];
                    end
                end
                svs_pkg::OFF_INIT_LEN: begin
                    init_len_r <= LW'(merge(32'(init_len_r), w_data_r, w_strb_r));
                end
                svs_pkg::OFF_MAIN_LEN: begin
                    main_len_r <= LW'(merge(32'(main_len_r), w_data_r, w_strb_r));
                end
                svs_pkg::OFF_COND: begin
                    cond_r <= merge(cond_r, w_data_r, w_strb_r);
                end
                svs_pkg::OFF_VEC_ADDR: begin
                    vec_addr_r <= MEM_AW'(merge(32'(vec_addr_r), w_data_r, w_strb_r));
                end
                svs_pkg::OFF_VEC_LO: begin
                    vec_lo_r <= merge(vec_lo_r, w_data_r, w_strb_r);
                end
                svs_pkg::OFF_VEC_HI: begin
                    vec_addr_r <= vec_addr_r + 1'b1;
                end
                default: begin
                end
            endcase
        end
    end

    // High half commits the word, whether running or stopped
    always_ff @(posedge i_clock) begin
        if (wr_go && aw_addr_r == svs_pkg::OFF_VEC_HI) begin
            mem[vec_addr_r] <= {w_data_r[IW-33:0], vec_lo_r};
        end
    end

    always_comb begin
        rd_hit  = 1'b1;
        rd_word = 32'h0000_0000;
        case (i_araddr)
            svs_pkg::OFF_CTRL:     rd_word = {29'h0, ext_clk_r, repeat_r, run_r};
            svs_pkg::OFF_STATUS:   rd_word = {29'h0, status_sys};
            svs_pkg::OFF_CLK_MHZ:  rd_word = {23'h0, clk_mhz_r};
            svs_pkg::OFF_STROBE:   rd_word = {26'h0, strobe_r};
            svs_pkg::OFF_INIT_LEN: rd_word = 32'(init_len_r);
            svs_pkg::OFF_MAIN_LEN: rd_word = 32'(main_len_r);
            svs_pkg::OFF_COND:     rd_word = cond_r;
            svs_pkg::OFF_VEC_ADDR: rd_word = 32'(vec_addr_r);
            svs_pkg::OFF_VEC_LO:   rd_word = vec_lo_r;
            default:               rd_hit  = (i_araddr == svs_pkg::OFF_VEC_HI);
        endcase
    end

    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_rvalid <= 1'b0;
            o_rdata  <= 32'h0000_0000;
            o_rresp  <= svs_pkg::RESP_OKAY;
        end else if (i_arvalid && o_arready) begin
            o_rvalid <= 1'b1;
            o_rdata  <= rd_word;
            o_rresp  <= rd_hit ? svs_pkg::RESP_OKAY : svs_pkg::RESP_SLVERR;
        end else if (i_rready) begin
            o_rvalid <= 1'b0;
        end
    end

    assign o_clk_ext_sel  = ext_clk_r;
    assign o_clk_mhz      = clk_mhz_r;
    assign o_strobe_delay = strobe_r;

    // ---------------- Link domain ----------------
    logic             run_lk;
    logic [2:0]       pat_lk;
    logic             arm_lk;
    logic [2:0]       status_lk;
    svs_state_t       state_r;
    logic [LW-1:0]    pc_r;
    logic [LW-1:0]    init_lk_r;
    logic [LW-1:0]    end_lk_r;
    logic             repeat_lk_r;
    logic [31:0]      cond_lk_r;
    logic [IW-1:0]    instr;
    logic [LW-1:0]    pc_next;
    logic             wrap;
    logic             cond_true;

    svs_sync #(.W(1)) u_run_sync (
        .i_clock   (i_vec_clock),
        .i_reset_n (i_reset_n),
        .i_async   (run_r),
        .o_sync    (run_lk)
    );

    svs_sync #(.W(4)) u_pin_sync (
        .i_clock   (i_vec_clock),
        .i_reset_n (i_reset_n),
        .i_async   ({i_arm_in, i_pattern}),
        .o_sync    ({arm_lk, pat_lk})
    );

    svs_sync #(.W(3)) u_status_sync (
        .i_clock   (i_clock),
        .i_reset_n (i_reset_n),
        .i_async   (status_lk),
        .o_sync    (status_sys)
    );

    assign instr   = mem[pc_r[MEM_AW-1:0]];
    assign pc_next = pc_r + 1'b1;
    assign wrap    = (pc_next >= end_lk_r);

    // Level test, so back-to-back waits on one held pattern pass
    always_comb begin
        if (instr[VEC_W+4:VEC_W+2] == svs_pkg::SEL_ARM_IN) begin
            cond_true = arm_lk;
        end else begin
            cond_true = cond_lk_r[{instr[VEC_W+3:VEC_W+2], pat_lk}];
        end
    end

    // Settings captured only while stopped; run sync is the handshake
    always_ff @(posedge i_vec_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_r     <= SVS_IDLE;
            pc_r        <= '0;
            init_lk_r   <= '0;
            end_lk_r    <= '0;
            repeat_lk_r <= 1'b0;
            cond_lk_r   <= 32'h0000_0000;
        end else if (!run_lk) begin
            state_r     <= SVS_IDLE;
            pc_r        <= '0;
            init_lk_r   <= init_len_r;
            end_lk_r    <= init_len_r + main_len_r;
            repeat_lk_r <= repeat_r;
            cond_lk_r   <= cond_r;
        end else begin
            case (state_r)
                SVS_IDLE: begin
                    state_r <= (end_lk_r == '0) ? SVS_DONE : SVS_PLAY;
                end
                SVS_PLAY: begin
                    if (instr[VEC_W+1:VEC_W] == svs_pkg::OP_WAIT && !cond_true) begin
                        state_r <= SVS_WAIT;
                    end else if (!wrap) begin
                        pc_r <= pc_next;
                    end else if (repeat_lk_r && init_lk_r < end_lk_r) begin
                        pc_r <= init_lk_r;
                    end else begin
                        state_r <= SVS_DONE;
                    end
                end
                SVS_WAIT: begin
                    if (cond_true) begin
                        state_r <= SVS_PLAY;
                        if (!wrap) begin
                            pc_r <= pc_next;
                        end else if (repeat_lk_r && init_lk_r < end_lk_r) begin
                            pc_r <= init_lk_r;
                        end else begin
                            state_r <= SVS_DONE;
                        end
                    end
                end
                SVS_DONE: begin
                end
                default: begin
                    state_r <= SVS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_vec_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_vector  <= '0;
            o_arm_out <= 1'b0;
        end else begin
            o_arm_out <= 1'b0;
            if (run_lk && state_r == SVS_PLAY) begin
                if (instr[VEC_W+1:VEC_W] == svs_pkg::OP_VECTOR) begin
                    o_vector <= instr[VEC_W-1:0];
                end
                o_arm_out <= (instr[VEC_W+1:VEC_W] == svs_pkg::OP_ARM);
            end
        end
    end

    always_ff @(posedge i_vec_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            status_lk <= 3'h0;
        end else begin
            status_lk <= {state_r == SVS_DONE, state_r == SVS_WAIT,
                          state_r == SVS_PLAY || state_r == SVS_WAIT};
        end
    end

    // Delay is added in the pod; this is the gated output clock
    assign o_strobe = i_vec_clock & run_lk;
endmodule // svs_sequencer

// file: verif/svs_sequencer_checker.sv
// Sequencer checker: bus handshakes, config ranges, link outputs.
// Bound into svs_sequencer; sees only its ports.
`timescale 1ns/1ps
module svs_sequencer_checker #(
    parameter int VEC_W = 48
) (
    input wire logic             i_clock,        // Bus clock
    input wire logic             i_reset_n,      // Reset, active low
    input wire logic             i_vec_clock,    // Output clock
    input wire logic             i_awvalid,      // AW valid
    input wire logic             o_awready,      // AW ready
    input wire logic             i_wvalid,       // W valid
    input wire logic             o_wready,       // W ready
    input wire logic [1:0]       o_bresp,        // B response
    input wire logic             o_bvalid,       // B valid
    input wire logic             i_bready,       // B ready
    input wire logic             i_arvalid,      // AR valid
    input wire logic             o_arready,      // AR ready
    input wire logic [31:0]      o_rdata,        // R data
    input wire logic             o_rvalid,       // R valid
    input wire logic             i_rready,       // R ready
    input wire logic [VEC_W-1:0] o_vector,       // Vector
    input wire logic             o_arm_out,      // Arm pulse
    input wire logic [8:0]       o_clk_mhz,      // Synth MHz
    input wire logic             o_strobe,       // Strobe
    input wire logic [5:0]       o_strobe_delay  // Strobe delay
);
    axi_b_hold_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp)) else $error("bresp dropped");
    axi_r_hold_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata)) else $error("rdata dropped");
    read_answer_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        i_arvalid && o_arready |=> o_rvalid && !o_arready) else $error("read not answered");
    write_answer_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        i_awvalid && o_awready && i_wvalid && o_wready |-> ##[1:2] o_bvalid)
        else $error("write not answered");
    clk_range_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        o_clk_mhz >= svs_pkg::CLK_MHZ_MIN && o_clk_mhz <= svs_pkg::CLK_MHZ_MAX)
        else $error("clock frequency out of range");
    strobe_max_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        o_strobe_delay <= svs_pkg::STROBE_MAX) else $error("strobe delay above limit");
    strobe_clock_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        o_strobe |-> i_vec_clock) else $error("strobe outside clock high phase");
    arm_vector_a: assert property (@(posedge i_vec_clock) disable iff (!i_reset_n)
        o_arm_out |-> $stable(o_vector)) else $error("arm word changed the vector");
endmodule // svs_sequencer_checker

bind svs_sequencer svs_sequencer_checker #(.VEC_W(VEC_W)) svs_sequencer_checker_inst (
    .i_clock, .i_reset_n, .i_vec_clock, .i_awvalid, .o_awready, .i_wvalid, .o_wready,
    .o_bresp, .o_bvalid, .i_bready, .i_arvalid, .o_arready, .o_rdata, .o_rvalid,
    .i_rready, .o_vector, .o_arm_out, .o_clk_mhz, .o_strobe, .o_strobe_delay);

// file: verif/svs_target_model.sv
// Far side: target showing a wait pattern, analyser answering arms.
// Assumes the bench sets the pattern and the re-arm delay.
`timescale 1ns/1ps
module svs_target_model (
    input wire logic       i_vec_clock, // Output clock
    input wire logic       i_reset_n,   // Reset, active low
    input wire logic       i_arm_out,   // Arming event from sequencer
    input wire logic [2:0] i_pat_set,   // Pattern the target shows
    input wire logic [7:0] i_arm_delay, // Analyser answer time, clocks
    output logic     [2:0] o_pattern,   // Wait pattern level
    output logic           o_arm_in,    // Arm back from analyser
    output logic     [7:0] o_arm_count  // Arm events seen
);
    logic [7:0] wait_cnt;
    always @(posedge i_vec_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_pattern <= 3'h0;
            o_arm_in <= 1'b0;
            o_arm_count <= 8'h00;
            wait_cnt <= 8'h00;
        end else begin
            o_pattern <= i_pat_set;
            if (wait_cnt != 8'h00) wait_cnt <= wait_cnt - 8'h01;
            if (wait_cnt == 8'h01) o_arm_in <= 1'b1;
            if (i_arm_out) begin
                o_arm_count <= o_arm_count + 8'h01;
                if (!o_arm_in) wait_cnt <= i_arm_delay;
            end
        end
    end
endmodule // svs_target_model

// file: verif/stimulus_vector_sequencer_tb.sv
// Bench: register rows over AXI4-Lite, then a program with arm and waits.
// Assumes svs_sequencer with a small vector store and the target model.
`timescale 1ns/1ps
module stimulus_vector_sequencer_tb;
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wd;
        logic [31:0] rd;
        logic [1:0]  br;
        logic [1:0]  rr;
    } svs_row_t;
    localparam logic [47:0] VA = 48'h8000_0000_0001, VB = 48'h0000_ffff_0000;
    localparam logic [47:0] VC = 48'h5a5a_a5a5_0f0f, VD = 48'hffff_0000_ffff;
    svs_row_t rows [8] = '{'{8'h08, 32'h12c, 32'h12c, 2'h0, 2'h0}, '{8'h08, 32'h0, 32'h1, 2'h0, 2'h0},
        '{8'h08, 32'h12d, 32'h12c, 2'h0, 2'h0}, '{8'h0c, 32'h28, 32'h20, 2'h0, 2'h0},
        '{8'h0c, 32'h0c, 32'h0c, 2'h0, 2'h0}, '{8'h00, 32'h4, 32'h4, 2'h0, 2'h0},
        '{8'h04, 32'h7, 32'h0, 2'h2, 2'h0}, '{8'h30, 32'h1, 32'h0, 2'h2, 2'h2}};
    logic i_clock, i_reset_n, i_vec_clock, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
    logic [7:0] i_awaddr, i_araddr, arm_delay, arm_count;
    logic [31:0] i_wdata, o_rdata, rd;
    logic [3:0] i_wstrb;
    logic [2:0] i_pattern, pat_set;
    logic i_arm_in, o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_arm_out;
    logic o_clk_ext_sel, o_strobe;
    logic [1:0] o_bresp, o_rresp, br, rr;
    logic [47:0] o_vector, last_vec;
    logic [8:0] o_clk_mhz;
    logic [5:0] o_strobe_delay;
    logic [47:0] seen_q [$];
    int failures, total_checks, c;

    svs_sequencer #(.MEM_AW(8)) svs_sequencer_inst (.i_clock, .i_reset_n, .i_vec_clock,
        .i_awaddr, .i_awvalid, .o_awready, .i_wdata, .i_wstrb, .i_wvalid, .o_wready, .o_bresp,
        .o_bvalid, .i_bready, .i_araddr, .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid,
        .i_rready, .i_pattern, .i_arm_in, .o_vector, .o_arm_out, .o_clk_ext_sel, .o_clk_mhz,
        .o_strobe, .o_strobe_delay);
    svs_target_model svs_target_model_inst (.i_vec_clock, .i_reset_n, .i_arm_out(o_arm_out),
        .i_pat_set(pat_set), .i_arm_delay(arm_delay), .o_pattern(i_pattern),
        .o_arm_in(i_arm_in), .o_arm_count(arm_count));

    initial begin
        i_clock = 1'b0;
        forever #10 i_clock = ~i_clock;
    end
    initial begin
        i_vec_clock = 1'b0;
        #1.7;
        forever #3 i_vec_clock = ~i_vec_clock;
    end
    // Sampled mid-cycle, once settled
    always @(negedge i_vec_clock) begin
        if (i_reset_n && o_vector !== last_vec) begin
            seen_q.push_back(o_vector);
            last_vec = o_vector;
        end
    end

    task automatic chk(input logic ok, input string msg);
        total_checks++;
        if (ok !== 1'b1) begin
            failures++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        logic [2:0] s;
        n = 0;
        @(posedge i_clock);
        {i_awaddr, i_wdata, i_awvalid, i_wvalid, i_bready} <= {a, d, 3'h7};
        do begin
            #1;
            s = {o_awready & i_awvalid, o_wready & i_wvalid, o_bvalid === 1'b1};
            r = o_bresp;
            @(posedge i_clock);
            n++;
            if (s[2]) i_awvalid <= 1'b0;
            if (s[1]) i_wvalid <= 1'b0;
        end while (!s[0] && n < 100);
        i_bready <= 1'b0;
        chk(n < 100, "write hang");
    endtask
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        logic [1:0] s;
        n = 0;
        @(posedge i_clock);
        {i_araddr, i_arvalid, i_rready} <= {a, 2'h3};
        do begin
            #1;
            s = {o_arready & i_arvalid, o_rvalid === 1'b1};
            {d, r} = {o_rdata, o_rresp};
            @(posedge i_clock);
            n++;
            if (s[1]) i_arvalid <= 1'b0;
        end while (!s[0] && n < 100);
        i_rready <= 1'b0;
        chk(n < 100, "read hang");
    endtask
    task automatic put(input logic [1:0] op, input logic [2:0] sel, input logic [47:0] v);
        axi_wr(svs_pkg::OFF_VEC_LO, v[31:0], br);
        axi_wr(svs_pkg::OFF_VEC_HI, {11'h0, sel, op, v[47:32]}, br);
    endtask
    task automatic wait_seen(input int n);
        c = 0;
        while (seen_q.size() < n && c < 400) begin
            @(posedge i_vec_clock);
            c++;
        end
    endtask
    task automatic finish_test;
        $display("checks %0d, mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        #200_000;
        failures++;
        $display("mismatch at %0t: watchdog expired", $time);
        finish_test;
    end
    initial begin
        {i_reset_n, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = '0;
        {i_awaddr, i_araddr, i_wdata, last_vec} = '0;
        i_wstrb = 4'hf;
        pat_set = 3'h3;
        arm_delay = 8'hc8;
        repeat (4) @(posedge i_clock);
        chk(o_clk_mhz === 9'h064 && o_vector === '0 && o_awready === 1'b1, "reset values");
        i_reset_n <= 1'b1;
        $display("reset test done");
        foreach (rows[i]) begin
            axi_wr(rows[i].addr, rows[i].wd, br);
            axi_rd(rows[i].addr, rd, rr);
            chk({br, rd, rr} === {rows[i].br, rows[i].rd, rows[i].rr}, "register row");
        end
        chk(o_clk_mhz === 9'h12c && o_strobe_delay === 6'h0c && o_clk_ext_sel === 1'b1,
            "config ports");
        $display("register test done");
        axi_wr(svs_pkg::OFF_INIT_LEN, 32'h2, br);
        axi_wr(svs_pkg::OFF_MAIN_LEN, 32'h5, br);
        axi_wr(svs_pkg::OFF_COND, 32'h60, br);
        axi_wr(svs_pkg::OFF_VEC_ADDR, 32'h0, br);
        put(svs_pkg::OP_VECTOR, 3'h0, VA);
        put(svs_pkg::OP_VECTOR, 3'h0, VB);
        put(svs_pkg::OP_ARM, 3'h0, '0);
        put(svs_pkg::OP_WAIT, 3'h0, '0);
        put(svs_pkg::OP_VECTOR, 3'h0, VC);
        put(svs_pkg::OP_WAIT, svs_pkg::SEL_ARM_IN, '0);
        put(svs_pkg::OP_VECTOR, 3'h0, VD);
        axi_wr(svs_pkg::OFF_CTRL, 32'h3, br);
        wait_seen(2);
        chk(seen_q[0] === VA && seen_q[1] === VB, "init vectors");
        repeat (60) @(posedge i_vec_clock);
        chk(seen_q.size() == 2 && arm_count === 8'h01, "wait or arm wrong");
        pat_set <= 3'h6;
        wait_seen(3);
        chk(seen_q[2] === VC && c <= 12, "pattern release");
        wait_seen(4);
        chk(seen_q[3] === VD && c > 100, "arm wait release");
        wait_seen(6);
        chk(seen_q[4] === VC && seen_q[5] === VD && arm_count >= 8'h02, "main loop");
        axi_wr(svs_pkg::OFF_CTRL, 32'h0, br);
        $display("program test done");
        finish_test;
    end
endmodule // stimulus_vector_sequencer_tb
